// >>> hdl/rtc_cmd_ctl.sv
// Remote terminal command acceptance, message checks and fail-safe
`timescale 1ns/1ns
`include "rtc_cfg.svh"
module rtc_cmd_ctl
    import rtc_pkg::*;
#(
    parameter bit OPT_BCAST = 1'b1,
    parameter bit OPT_OVERRIDE = 1'b1,
    parameter bit OPT_RESET = 1'b1,
    parameter bit MULTI_BUS = 1'b0,
    parameter bit ILLEGAL_CHK = 1'b1,
    parameter logic [31:0] LEGAL_RX_SA = 32'hFFFFFFFF,
    parameter logic [31:0] LEGAL_TX_SA = 32'hFFFFFFFF,
    parameter logic [31:0] LEGAL_MODE = 32'hFFFFFFFF,
    parameter int FS_CYC = `RTC_FAILSAFE_NS / `RTC_CLK_NS
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] rx_p,
    input wire logic [1:0] rx_n,
    input wire logic [4:0] rt_addr,
    input wire logic [1:0] tx_busy,
    output logic cmd_stb,
    output rtc_cmd_t cmd,
    output logic cmd_bus,
    output logic data_stb,
    output logic [15:0] data_word,
    output logic msg_done,
    output logic msg_ok,
    output logic status_req,
    output logic status_bus,
    output logic status_msg_err,
    output logic status_bcast,
    output logic [1:0] tx_inhibit,
    output logic rt_reset
);
    // ------------------------------------------------------------
    // Derived counts
    // ------------------------------------------------------------
    localparam int RSP_CYC = (`RTC_RSP_NS + `RTC_CLK_NS - 1) / `RTC_CLK_NS;
    localparam int REPLY_CYC = `RTC_REPLY_NS / `RTC_CLK_NS;
    localparam int FSW = $clog2(FS_CYC + 2);
    localparam logic [4:0] OVR_MC = MULTI_BUS ? `RTC_MC_OVRN : `RTC_MC_OVR2;

    rtc_word_t wd [2];
    logic [1:0] stb, werr, gap, hit, take, fs_clr;
    logic [4:0] rt_addr_m, rt_addr_s;
    rtc_state_t st;
    rtc_cmd_t cur_cmd;
    logic cur_bus, cur_ill, saw;
    logic [5:0] left;
    logic [7:0] rsp_cnt;

    // Address strap crosses in through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rt_addr_m <= 5'h00;
            rt_addr_s <= 5'h00;
        end else begin
            rt_addr_m <= rt_addr;
            rt_addr_s <= rt_addr_m;
        end
    end

    // ------------------------------------------------------------
    // Selected command decode
    // ------------------------------------------------------------
    wire logic busy_st = (st == ST_RSP) || (st == ST_TX);
    wire logic take_any = |take;
    wire logic tb = ~take[0];
    wire logic [15:0] sw = wd[tb].data;
    wire logic s_tr = sw[`RTC_TR_BIT];
    wire logic [4:0] s_sa = sw[`RTC_SA_LSB +: 5];
    wire logic [4:0] s_wc = sw[`RTC_WC_LSB +: 5];
    wire logic s_bc = sw[`RTC_ADDR_LSB +: 5] == `RTC_BCAST_ADDR;
    wire logic s_mode = s_sa == `RTC_MODE_SA0 || s_sa == `RTC_MODE_SA1; // R19
    wire logic [5:0] s_dw = (s_wc == 5'h00) ? `RTC_WC_ZERO : {1'b0, s_wc};
    wire logic [5:0] s_need = s_mode ? {5'h00, ~s_tr & s_wc[4]} : (s_tr ? 6'h00 : s_dw);
    wire logic s_bad = s_mode ? ~LEGAL_MODE[s_wc] : (s_tr ? ~LEGAL_TX_SA[s_sa] : ~LEGAL_RX_SA[s_sa]);
    wire logic s_ill = ILLEGAL_CHK & s_bad; // R14
    wire logic keep_stat = s_mode && s_wc == `RTC_MC_TXSTAT;

    // Data words on the bus of the message in progress
    wire logic dstb = stb[cur_bus] & ~wd[cur_bus].is_cmd;
    wire logic dgood = dstb & wd[cur_bus].contig; // R20
    wire logic rx_st = (st == ST_RXD) && !take_any;
    wire logic derr = rx_st && ((stb[cur_bus] && !dgood) || werr[cur_bus] || gap[cur_bus]); // R2

    // Message completion, from a command alone or its last data word
    wire logic fin_now = (take_any && s_need == 6'h00) || (rx_st && dgood && left == 6'h01);
    wire rtc_cmd_t f_cmd = take_any ? rtc_cmd_t'({s_bc, sw}) : cur_cmd;
    wire logic f_ill = take_any ? s_ill : cur_ill;
    wire logic f_bus = take_any ? tb : cur_bus;
    wire logic f_mode = f_cmd.sa == `RTC_MODE_SA0 || f_cmd.sa == `RTC_MODE_SA1;
    wire logic f_act = fin_now && !f_ill && f_mode;
    wire logic act_rst = OPT_RESET && f_act && f_cmd.wc == `RTC_MC_RESET; // R7
    wire logic act_ovr = OPT_OVERRIDE && f_act && f_cmd.wc == OVR_MC; // R6

    // ------------------------------------------------------------
    // Per-bus receiver, address match and fail-safe timer
    // ------------------------------------------------------------
    for (genvar b = 0; b < 2; b++) begin : g_bus
        logic [FSW-1:0] fs_cnt;
        wire logic [4:0] adr = wd[b].data[`RTC_ADDR_LSB +: 5];
        wire logic bc_hit = OPT_BCAST && adr == `RTC_BCAST_ADDR;

        rtc_word_rx u_rx (
            .clk(clk),
            .resetn(resetn),
            .rx_p(rx_p[b]),
            .rx_n(rx_n[b]),
            .word(wd[b]),
            .word_stb(stb[b]),
            .word_err(werr[b]),
            .gap_stb(gap[b])
        );

        // Invalid words never reach here, so outside ST_RXD they cannot disturb status
        assign hit[b] = stb[b] & wd[b].is_cmd & ((adr == rt_addr_s) | bc_hit); // R9 R12
        assign take[b] = hit[b] & ~(busy_st && cur_bus == 1'(b)); // R10
        assign fs_clr[b] = hit[b] | act_rst | (act_ovr && f_bus != 1'(b)); // R5 R6 R7

        // Counts one unbroken transmission; trip holds until cleared
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                fs_cnt <= '0;
                tx_inhibit[b] <= 1'b0;
            end else if (fs_clr[b]) begin
                fs_cnt <= '0;
                tx_inhibit[b] <= 1'b0;
            end else if (!tx_busy[b]) begin
                fs_cnt <= '0;
            end else if (fs_cnt == FSW'(FS_CYC - 1)) begin
                tx_inhibit[b] <= 1'b1; // R3 R4
            end else begin
                fs_cnt <= fs_cnt + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Message sequencer
    // ------------------------------------------------------------
    // A newer command wins over the message in progress, unless it comes on the busy bus in ST_RSP or ST_TX
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= ST_IDLE;
            {cmd_stb, cmd_bus, data_stb, msg_done, msg_ok} <= 5'h00;
            {status_req, status_bus, status_msg_err, status_bcast} <= 4'h0;
            {rt_reset, cur_bus, cur_ill, saw} <= 4'h0;
            cmd <= '0;
            cur_cmd <= '0;
            data_word <= 16'h0000;
            left <= 6'h00;
            rsp_cnt <= 8'h00;
        end else begin
            cmd_stb <= 1'b0;
            data_stb <= 1'b0;
            msg_done <= 1'b0;
            status_req <= 1'b0;
            rt_reset <= act_rst; // R7
            if (take_any) begin
                cmd_stb <= 1'b1; // R11
                cmd <= f_cmd;
                cmd_bus <= tb;
                cur_cmd <= f_cmd;
                cur_bus <= tb;
                cur_ill <= s_ill;
                left <= s_need;
                st <= ST_RXD;
                if (!keep_stat) begin
                    status_msg_err <= 1'b0;
                    status_bcast <= 1'b0;
                end
            end else begin
                case (st)
                    ST_IDLE: begin
                        rsp_cnt <= 8'h00;
                    end
                    ST_RXD: begin
                        if (derr) begin
                            msg_done <= 1'b1; // R2
                            msg_ok <= 1'b0;
                            status_msg_err <= 1'b1;
                            st <= ST_IDLE;
                        end else if (dgood) begin
                            left <= left - 6'h01;
                            data_stb <= ~cur_ill; // R15
                            data_word <= wd[cur_bus].data;
                        end
                    end
                    ST_RSP: begin
                        rsp_cnt <= rsp_cnt + 8'h01;
                        if (rsp_cnt == 8'(RSP_CYC - 1)) begin
                            status_req <= 1'b1; // R18
                            status_bus <= cur_bus;
                            rsp_cnt <= 8'h00;
                            saw <= 1'b0;
                            st <= ST_TX;
                        end
                    end
                    ST_TX: begin
                        rsp_cnt <= rsp_cnt + 8'h01;
                        if (tx_busy[cur_bus]) begin
                            saw <= 1'b1;
                        end
                        // Give up if the transmitter never starts
                        if ((saw && !tx_busy[cur_bus]) || tx_inhibit[cur_bus]
                            || (!saw && rsp_cnt == 8'(RSP_CYC - 1))) begin
                            st <= ST_IDLE;
                        end
                    end
                    default: begin
                        st <= ST_IDLE;
                    end
                endcase
            end
            if (fin_now) begin
                msg_done <= 1'b1;
                msg_ok <= ~f_ill;
                rsp_cnt <= 8'h00;
                if (f_ill) begin
                    status_msg_err <= 1'b1; // R15
                end
                if (f_cmd.bcast) begin
                    status_bcast <= 1'b1;
                    st <= ST_IDLE;
                end else begin
                    st <= ST_RSP;
                end
            end
            if (act_rst) begin
                status_msg_err <= 1'b0; // R7
                status_bcast <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [FSW:0] run0;
    logic [7:0] since_done;

    // Helper counters seen only by the checks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run0 <= '0;
            since_done <= 8'h00;
        end else begin
            run0 <= tx_busy[0] ? run0 + 1'b1 : '0;
            since_done <= (fin_now || take_any) ? 8'h00 : since_done + 8'h01;
        end
    end

    property p_cmd_addr;
        @(posedge clk) disable iff (!resetn)
        cmd_stb |-> (cmd.addr == rt_addr_s) || (OPT_BCAST && cmd.addr == `RTC_BCAST_ADDR);
    endproperty
    a_cmd_addr: assert property (p_cmd_addr) else $error("foreign command accepted"); // R9

    property p_invalid_quiet;
        @(posedge clk) disable iff (!resetn)
        (werr != 2'b00 && stb == 2'b00 && st != ST_RXD) |=> !cmd_stb && $stable(status_msg_err);
    endproperty
    a_invalid_quiet: assert property (p_invalid_quiet) else $error("invalid word acted on"); // R12

    property p_rsp_time;
        @(posedge clk) disable iff (!resetn)
        status_req |-> since_done == 8'(RSP_CYC);
    endproperty
    a_rsp_time: assert property (p_rsp_time) else $error("status request mistimed"); // R18

    property p_fs_trip;
        @(posedge clk) disable iff (!resetn)
        (run0 == (FSW+1)'(FS_CYC) && !fs_clr[0]) |=> tx_inhibit[0];
    endproperty
    a_fs_trip: assert property (p_fs_trip) else $error("fail-safe did not trip"); // R3

    property p_fs_late;
        @(posedge clk) disable iff (!resetn)
        $rose(tx_inhibit[0]) |-> run0 > (FSW+1)'(REPLY_CYC);
    endproperty
    a_fs_late: assert property (p_fs_late) else $error("fail-safe cut a legal reply"); // R4

    property p_fs_clear;
        @(posedge clk) disable iff (!resetn)
        (tx_inhibit[0] && hit[0]) |=> !tx_inhibit[0];
    endproperty
    a_fs_clear: assert property (p_fs_clear) else $error("command did not clear fail-safe"); // R5

    property p_override;
        @(posedge clk) disable iff (!resetn)
        (act_ovr && f_bus) |=> !tx_inhibit[0];
    endproperty
    a_override: assert property (p_override) else $error("override did not clear"); // R6

    property p_reset_mode;
        @(posedge clk) disable iff (!resetn)
        act_rst |=> rt_reset && tx_inhibit == 2'b00 && !status_msg_err;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset mode incomplete"); // R7

    property p_busy_block;
        @(posedge clk) disable iff (!resetn)
        (busy_st && hit[cur_bus] && !hit[~cur_bus]) |=> !cmd_stb;
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("command taken while replying"); // R10

    property p_supersede;
        @(posedge clk) disable iff (!resetn)
        (st == ST_RXD && take_any) |=> cmd_stb && (st != ST_IDLE || status_bcast || rt_reset);
    endproperty
    a_supersede: assert property (p_supersede) else $error("new command not taken"); // R11

    property p_msg_err;
        @(posedge clk) disable iff (!resetn)
        (msg_done && !msg_ok) |-> status_msg_err;
    endproperty
    a_msg_err: assert property (p_msg_err) else $error("message error bit not set"); // R2 R15

    c_accept: cover property (@(posedge clk) disable iff (!resetn) cmd_stb);
    c_reply: cover property (@(posedge clk) disable iff (!resetn) status_req);
    c_trip: cover property (@(posedge clk) disable iff (!resetn) $rose(tx_inhibit[0]));
    c_error: cover property (@(posedge clk) disable iff (!resetn) msg_done && !msg_ok);
endmodule : rtc_cmd_ctl

// >>> hdl/rtc_cfg.svh
// Constants for the terminal command validation block
// Function
// [R1] Word valid needs sync, Manchester, odd parity
// [R2] Message words contiguous, late data sync errors
// [R3] Hardware timeout stops transmission past 800us
// [R4] Timeout longer than the longest legal reply
// [R5] Valid command on tripped bus clears timeout
// [R6] Override shutdown mode on other bus clears
// [R7] Reset mode restores power-up state, clears timer
// [R8] Only one active controller per bus
// [R9] Accept command for own or broadcast address
// [R10] Accept commands except in response or transmit; the code still takes a command on the other bus then
// [R11] Newer valid command supersedes the earlier one
// [R12] Invalid command: no response, status unchanged
// [R13] Invalid command resets receiver to hunt again
// [R14] Optional detection of unimplemented command functions
// [R15] Illegal command: status only, error bit, discard
// [R16] Controller never sends illegal commands
// [R17] Controller leaves 4us between messages
// [R18] Status reply starts 4 to 12us after
// [R19] Subaddress 00000 or 11111 means mode command
// [R20] Message words sent back to back
// [R21] Word is sync, 16 bits, parity bit
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RTC_CLK_NS 40
`define RTC_HALF_NS 500
`define RTC_DEAD_NS 2000
`define RTC_CONTIG_NS 4000
`define RTC_RSP_NS 6000
`define RTC_FAILSAFE_NS 800000
`define RTC_REPLY_NS 660000

// ----------------------------------------------------------------
// Word format and codes
// ----------------------------------------------------------------
`define RTC_HALVES 34
`define RTC_SYNC_CMD 6'h38
`define RTC_SYNC_DATA 6'h07
`define RTC_ADDR_LSB 11
`define RTC_TR_BIT 10
`define RTC_SA_LSB 5
`define RTC_WC_LSB 0
`define RTC_BCAST_ADDR 5'h1F
`define RTC_MODE_SA0 5'h00
`define RTC_MODE_SA1 5'h1F
`define RTC_MC_TXSTAT 5'h02
`define RTC_MC_OVR2 5'h05
`define RTC_MC_OVRN 5'h15
`define RTC_MC_RESET 5'h08
`define RTC_WC_ZERO 6'h20

`endif

// >>> hdl/rtc_pkg.sv
// Types shared by the terminal command validation block
package rtc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_RXD, ST_RSP, ST_TX} rtc_state_t;
    typedef struct packed {
        logic is_cmd;
        logic contig;
        logic [15:0] data;
    } rtc_word_t;
    typedef struct packed {
        logic bcast;
        logic [4:0] addr;
        logic tr;
        logic [4:0] sa;
        logic [4:0] wc;
    } rtc_cmd_t;
endpackage : rtc_pkg

// >>> hdl/rtc_word_rx.sv
// Manchester word receiver for one bus
`timescale 1ns/1ns
`include "rtc_cfg.svh"
module rtc_word_rx
    import rtc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic rx_p,
    input wire logic rx_n,
    output rtc_word_t word,
    output logic word_stb,
    output logic word_err,
    output logic gap_stb
);
    // ------------------------------------------------------------
    // Half-bit sample points after the last line edge
    // ------------------------------------------------------------
    localparam logic [5:0] SMP0 = 6'((`RTC_HALF_NS / 2) / `RTC_CLK_NS);
    localparam logic [5:0] SMP1 = 6'((`RTC_HALF_NS * 3 / 2) / `RTC_CLK_NS);
    localparam logic [5:0] SMP2 = 6'((`RTC_HALF_NS * 5 / 2) / `RTC_CLK_NS);
    localparam logic [5:0] SMP3 = 6'((`RTC_HALF_NS * 7 / 2) / `RTC_CLK_NS);
    localparam logic [5:0] DEAD = 6'(`RTC_DEAD_NS / `RTC_CLK_NS);
    localparam logic [7:0] CONTIG = 8'(`RTC_CONTIG_NS / `RTC_CLK_NS);

    logic p_m, p_s, n_m, n_s, p_d, n_d;
    logic [5:0] cnt, hunt_sh, hunt_ok, nh;
    logic coll, is_cmd_q, bad, contig_q, par_q;
    logic [33:0] sr;
    logic [7:0] gap;
    logic man_ok;
    logic [16:0] bits;

    // Edges resync the sampler; Manchester guarantees one per bit
    wire logic rail_edge = (p_s != p_d) | (n_s != n_d);
    wire logic smp = !rail_edge && (cnt == SMP0 || cnt == SMP1 || cnt == SMP2 || cnt == SMP3);
    wire logic hb = p_s & ~n_s;
    wire logic hbad = (p_s == n_s);
    wire logic [5:0] nsh = {hunt_sh[4:0], hb};
    wire logic [5:0] nok = {hunt_ok[4:0], ~hbad};
    wire logic sync_c = (&nok) && nsh == `RTC_SYNC_CMD; // R21
    wire logic sync_d = (&nok) && nsh == `RTC_SYNC_DATA; // R21
    wire logic dead = coll && cnt >= DEAD;
    wire logic last = coll && smp && nh == 6'(`RTC_HALVES - 1);
    wire logic [33:0] fsr = {sr[32:0], hb};

    // Pair check and bit extraction, first bit in time is the MSB
    always_comb begin
        man_ok = 1'b1;
        bits = '0;
        for (int j = 0; j < 17; j++) begin
            man_ok = man_ok & (fsr[33 - 2 * j] ^ fsr[32 - 2 * j]); // R1
            bits[16 - j] = fsr[33 - 2 * j];
        end
    end
    wire logic fbad = bad | hbad | !man_ok | !(^bits); // R1

    // Two flops on each line rail before any logic
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {p_m, p_s, n_m, n_s, p_d, n_d} <= 6'h00;
        end else begin
            {p_m, p_s, p_d} <= {rx_p, p_m, p_s};
            {n_m, n_s, n_d} <= {rx_n, n_m, n_s};
        end
    end

    // Clocks since last edge, saturating when the line is dead
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 6'h3F;
        end else if (rail_edge) begin
            cnt <= 6'h00;
        end else if (cnt != 6'h3F) begin
            cnt <= cnt + 6'h01;
        end
    end

    // Gap since last word end; a late sync is not contiguous
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap <= 8'hFF;
        end else if (last || dead) begin
            gap <= dead ? 8'hFF : 8'h00;
        end else if (!coll && gap != 8'hFF) begin
            gap <= gap + 8'h01;
        end
    end
    assign gap_stb = !coll && gap == CONTIG + 8'h01; // R2

    // Hunt for sync, then collect 34 half bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {coll, is_cmd_q, bad, contig_q, par_q} <= 5'h00;
            {word_stb, word_err} <= 2'h0;
            hunt_sh <= 6'h00;
            hunt_ok <= 6'h00;
            nh <= 6'h00;
            sr <= '0;
            word <= '0;
        end else begin
            word_stb <= 1'b0;
            word_err <= 1'b0;
            if (!coll) begin
                if (smp) begin
                    hunt_sh <= nsh;
                    hunt_ok <= nok;
                    coll <= sync_c | sync_d;
                    is_cmd_q <= sync_c;
                    contig_q <= gap <= CONTIG; // R2
                    nh <= 6'h00;
                    bad <= 1'b0;
                end
            end else if (dead) begin
                coll <= 1'b0; // R13
                word_err <= 1'b1;
                hunt_ok <= 6'h00;
            end else if (smp) begin
                sr <= fsr;
                bad <= bad | hbad;
                nh <= nh + 6'h01;
                if (last) begin
                    coll <= 1'b0; // R13
                    hunt_ok <= 6'h00;
                    word_err <= fbad;
                    word_stb <= !fbad; // R1
                    word <= '{is_cmd: is_cmd_q, contig: contig_q, data: bits[16:1]};
                    par_q <= bits[0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_word_parity;
        @(posedge clk) disable iff (!resetn)
        word_stb |-> (^{word.data, par_q}) == 1'b1;
    endproperty
    a_word_parity: assert property (p_word_parity) else $error("even parity word passed"); // R1
endmodule : rtc_word_rx

// >>> tb/rtc_bc_model.sv
// Bus controller model: Manchester words on either bus
`timescale 1ns/1ns
`include "rtc_cfg.svh"
module rtc_bc_model (
    output logic [1:0] rx_p,
    output logic [1:0] rx_n
);
    // Both rails low while no controller drives
    initial begin
        rx_p = 2'h0;
        rx_n = 2'h0;
    end
    // One word, sync then bits; words sent back to back stay contiguous
    task automatic send(input logic b, input logic c, input logic [15:0] d, input logic bad);
        logic [39:0] h;
        logic [16:0] w;
        w = {d, ~^d ^ bad};
        h = {34'h0, c ? `RTC_SYNC_CMD : `RTC_SYNC_DATA};
        for (int i = 16; i >= 0; i--) begin
            h = {h[37:0], w[i], ~w[i]};
        end
        // Edges sit 10 ns off every clock edge; the word still spans 20 us
        #10;
        for (int i = 39; i >= 0; i--) begin
            rx_p[b] = h[i];
            rx_n[b] = ~h[i];
            #((i == 0) ? `RTC_HALF_NS - 10 : `RTC_HALF_NS);
        end
        rx_p[b] = 1'b0;
        rx_n[b] = 1'b0;
    endtask : send
endmodule : rtc_bc_model

// >>> tb/rtc_cmd_ctl_tb.sv
// Testbench for the terminal command validation block
`timescale 1ns/1ns
module rtc_cmd_ctl_tb;
    import rtc_pkg::*;
    logic clk, resetn, cmd_stb, cmd_bus, data_stb, msg_done, msg_ok, status_req;
    logic status_bus, status_msg_err, status_bcast, rt_reset, last_ok;
    logic [1:0] rx_p, rx_n, tx_busy, tx_inhibit;
    logic [4:0] rt_addr;
    logic [15:0] data_word;
    rtc_cmd_t cmd;
    int bad_count = 0, checks = 0, cyc = 0, t_done = 0, t_req = 0;
    int n_cmd, n_dat, n_req, n_rst;
    // Subaddress 6 unimplemented; only the illegal scenario sends it
    rtc_cmd_ctl #(.LEGAL_RX_SA(32'hFFFFFFBF)) rtc_cmd_ctl_i (.clk(clk), .resetn(resetn),
        .rx_p(rx_p), .rx_n(rx_n),
        .rt_addr(rt_addr), .tx_busy(tx_busy), .cmd_stb(cmd_stb), .cmd(cmd),
        .cmd_bus(cmd_bus), .data_stb(data_stb), .data_word(data_word),
        .msg_done(msg_done), .msg_ok(msg_ok), .status_req(status_req),
        .status_bus(status_bus), .status_msg_err(status_msg_err),
        .status_bcast(status_bcast), .tx_inhibit(tx_inhibit), .rt_reset(rt_reset));
    rtc_bc_model rtc_bc_model_i (.rx_p(rx_p), .rx_n(rx_n));
    // ----------------------------------------------------------------
    // Clock, event counters and hang limit
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        n_cmd += (cmd_stb === 1'b1);
        n_dat += (data_stb === 1'b1);
        n_req += (status_req === 1'b1);
        n_rst += (rt_reset === 1'b1);
        if (msg_done === 1'b1) begin
            last_ok = msg_ok;
            t_done = cyc;
        end
        if (status_req === 1'b1) t_req = cyc;
        if (cyc == 90000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task report_and_stop;
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    // Clear counts, and long settle so response wait has expired
    task clr;
        n_cmd = 0;
        n_dat = 0;
        n_req = 0;
        n_rst = 0;
    endtask : clr
    task settle;
        repeat (400) @(negedge clk);
    endtask : settle
    task snd(input logic b, input logic c, input logic [15:0] d, input logic bad);
        rtc_bc_model_i.send(b, c, d, bad);
    endtask : snd
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_rx_ok;
        clr();
        snd(0, 1, 16'h2862, 0);
        snd(0, 0, 16'hA5C3, 0);
        snd(0, 0, 16'h0F0F, 0);
        settle();
        chk("cmd", {1'b0, 16'h2862}, 32'(cmd));
        chk("data", 2, n_dat);
        chk("word", 16'h0F0F, data_word);
        chk("ok", 1, last_ok);
        chk("gap", 150, t_req - t_done);
    endtask : t_rx_ok
    // Bad parity, then a good one at once; foreign address on bus 1
    task t_reject;
        clr();
        snd(0, 1, 16'h2C24, 1);
        snd(0, 1, 16'h2C24, 0);
        snd(1, 1, 16'h3424, 0);
        settle();
        chk("cmds", 1, n_cmd);
        chk("reqs", 1, n_req);
    endtask : t_reject
    task t_bcast;
        clr();
        snd(1, 1, 16'hF841, 0);
        snd(1, 0, 16'h1234, 0);
        settle();
        chk("bc", 1, status_bcast);
        chk("bcreq", 0, n_req);
    endtask : t_bcast
    // Data sync arriving 6 us late
    task t_late;
        clr();
        snd(0, 1, 16'h2861, 0);
        #6000;
        snd(0, 0, 16'h5555, 0);
        settle();
        chk("late", 0, last_ok);
        chk("merr", 1, status_msg_err);
        chk("lreq", 0, n_req);
    endtask : t_late
    // A second command right behind the first supersedes it
    task t_super;
        clr();
        snd(1, 1, 16'h2862, 0);
        snd(1, 1, 16'h2C24, 0);
        settle();
        chk("scmd", 2, n_cmd);
        chk("sdat", 0, n_dat);
        chk("sreq", 1, n_req);
        chk("sok", 1, last_ok);
        chk("cbus", 1, cmd_bus);
        chk("sbus", 1, status_bus);
    endtask : t_super
    // Unimplemented subaddress, then an own command while transmitting
    task t_illegal;
        clr();
        snd(0, 1, 16'h28C1, 0);
        snd(0, 0, 16'h1357, 0);
        @(negedge clk) tx_busy[0] = 1'b1;
        snd(0, 1, 16'h2C24, 0);
        @(negedge clk) tx_busy[0] = 1'b0;
        settle();
        chk("idat", 0, n_dat);
        chk("iok", 0, last_ok);
        chk("ierr", 1, status_msg_err);
        chk("ireq", 1, n_req);
        chk("busy", 1, n_cmd);
    endtask : t_illegal
    // Transmitter stuck on bus 0, then cleared by command word w on bus b
    task trip(input logic b, input logic [15:0] w);
        @(negedge clk) tx_busy[0] = 1'b1;
        repeat (19990) @(negedge clk);
        chk("early", 0, tx_inhibit[0]);
        repeat (15) @(negedge clk);
        chk("trip", 1, tx_inhibit[0]);
        tx_busy[0] = 1'b0;
        snd(b, 1, w, 0);
        settle();
        chk("clear", 0, tx_inhibit[0]);
    endtask : trip
    initial begin
        resetn = 1'b0;
        tx_busy = 2'h0;
        rt_addr = 5'h05;
        clr();
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (5) @(negedge clk);
        t_rx_ok();
        t_reject();
        t_bcast();
        t_late();
        t_super();
        t_illegal();
        trip(0, 16'h2C24);
        trip(1, 16'h2C05);
        clr();
        trip(1, 16'h2FE8);
        chk("rst", 1, n_rst);
        report_and_stop();
    end
endmodule : rtc_cmd_ctl_tb
